// *** rtl/srs_regs.vh ***
`ifndef SRS_REGS_VH
`define SRS_REGS_VH

// oscillator settling hold, 15 to 30 ms; least time taken, rounded up
`define SRS_CLK_MHZ 100
`define SRS_SETTLE_US 15000
`define SRS_SETTLE_CYC (`SRS_SETTLE_US * `SRS_CLK_MHZ)
// brown-out condition hold-off
`define SRS_BOR_HOLD_US 500
`define SRS_BOR_HOLD_CYC (`SRS_BOR_HOLD_US * `SRS_CLK_MHZ)
// internal reset pulse width for in-service resets
`define SRS_PULSE_CYC 16
// brown-out interrupt noise filter depth, in samples
`define SRS_FILT_LEN 4

// reset cause bit positions
`define SRS_CAUSE_EXT 0
`define SRS_CAUSE_POR 1
`define SRS_CAUSE_BOR 2
`define SRS_CAUSE_WDT 3
`define SRS_CAUSE_SW 4
`define SRS_CAUSE_LDO 5
`define SRS_CAUSE_W 6

// boot fetch phases
`define SRS_FETCH_SP 2'h0
`define SRS_FETCH_PC 2'h1
`define SRS_FETCH_INSN 2'h2
`define SRS_FETCH_RUN 2'h3

`endif

// *** rtl/srs_reset_sequencer.v ***
// Operation
// - wait for later of pin and power-on release
// - hold reset during oscillator settling count
// - boot fetch: stack pointer, PC, instruction, run
// - power-on detector acts only at first power-up
// - power-on resets test port; pin does not
// - brown-out reset disabled after reset, software enables
// - brown-out gives interrupt, or reset when selected
// - optional resample of brown-out interrupt after delay, drop if gone
// - optional noise filter on brown-out interrupt
// - brown-out reset, taken without resample, pulses reset, then boot
// - brown-out flag clears after 500 us, blocks re-set
// - peripheral reset on set-then-clear of its bit
// - soft reset bits follow clock-gating bit order
// - soft reset hits every clock domain of peripheral
// - core reset request resets core and peripherals, not test port, then boots
// - watchdog resets on second time-out if enabled
// - watchdog reset pulses reset, then boots
// - regulator-loss reset enabled by software, sets flag
// - sticky cause bits; pin reset clears others
// - pin reset spares test port, same settling hold
`timescale 1ns/1ps
`include "srs_regs.vh"

module srs_reset_sequencer #(
    parameter NUM_PERIPH = 32,
    parameter NUM_DOMAINS = 2,
    parameter SETTLE_CYC = `SRS_SETTLE_CYC,
    parameter BOR_HOLD_CYC = `SRS_BOR_HOLD_CYC,
    parameter DELAY_W = 16
) (
    input wire sys_clk,
    input wire rst_b,
    input wire clk_en,
    input wire ext_reset_pin_b,
    input wire por_detect,
    input wire brownout_detect,
    input wire brownout_reset_ctrl_en,
    input wire brownout_reset_select,
    input wire brownout_resample_en,
    input wire [DELAY_W-1:0] brownout_resample_delay,
    input wire brownout_filter_en,
    input wire [NUM_PERIPH-1:0] periph_soft_reset_regs,
    input wire core_system_reset_request,
    input wire wdt_timeout,
    input wire wdt_int_pending,
    input wire wdt_reset_en,
    input wire regulator_reset_en,
    input wire regulator_unregulated,
    input wire cause_clear,
    output reg sys_reset_q,
    output reg tap_reset_q,
    output reg [1:0] boot_phase_q,
    output reg brownout_int_q,
    output reg brownout_flag_q,
    output reg regulator_reset_flag,
    output reg [`SRS_CAUSE_W-1:0] reset_cause_reg,
    output reg [NUM_PERIPH*NUM_DOMAINS-1:0] periph_reset_q
);

// states of the reset sequence
localparam ST_POWERUP = 3'h0;
localparam ST_SETTLE = 3'h1;
localparam ST_PULSE = 3'h2;
localparam ST_FETCH = 3'h3;
localparam ST_RUN = 3'h4;

// one counter serves settle and pulse; wide enough for the longest settle count
reg [2:0] state_q;
reg [31:0] cnt_q;
reg por_seen_q;
reg [31:0] bor_cnt_q;
reg bor_wait_q;
reg [DELAY_W-1:0] bor_res_q;
reg [`SRS_FILT_LEN-1:0] filt_q;
reg wdt_first_q;
reg [NUM_PERIPH-1:0] soft_prev_q;
reg bor_enable_q;

wire pin_active;
wire por_active;
wire hold_inputs;
wire filt_ok;
wire bor_fire_now;
wire bor_go_reset;
wire wdt_second;
wire ldo_reset;
wire bor_reset;
wire sw_reset;
wire svc_reset;

////////////////////////////////////////////////////////////////////////
// source decode

assign pin_active = ~ext_reset_pin_b;
// power-on detector only counts before the first release
assign por_active = por_detect & ~por_seen_q;
assign hold_inputs = pin_active | por_active;
// filter only gates the interrupt path; reset path uses the raw comparator
assign filt_ok = brownout_filter_en ? &filt_q : brownout_detect;
assign bor_fire_now = brownout_detect & ~brownout_flag_q;
// brown-out reset needs both the enable and the select
assign bor_go_reset = bor_enable_q & brownout_reset_select;
// second zero while the first interrupt is still pending
assign wdt_second = wdt_timeout & wdt_first_q & wdt_int_pending & wdt_reset_en;
// regulator loss only counts once software has armed it
assign ldo_reset = regulator_reset_en & regulator_unregulated;
assign bor_reset = bor_fire_now & bor_go_reset;
assign sw_reset = core_system_reset_request;
// one level for every in-service source; pin and power-on go through the sequence
assign svc_reset = bor_reset | wdt_second | ldo_reset | sw_reset;

////////////////////////////////////////////////////////////////////////
// main sequence

always @(posedge sys_clk) begin
    if (!rst_b) begin
        state_q <= ST_POWERUP;
        cnt_q <= 32'h0;
        por_seen_q <= 1'b0;
        sys_reset_q <= 1'b1;
        tap_reset_q <= 1'b1;
        boot_phase_q <= `SRS_FETCH_SP;
        bor_enable_q <= 1'b0;
        reset_cause_reg <= {`SRS_CAUSE_W{1'b0}};
        regulator_reset_flag <= 1'b0;
    end else if (clk_en) begin
        bor_enable_q <= brownout_reset_ctrl_en;
        if (cause_clear)
            reset_cause_reg <= {`SRS_CAUSE_W{1'b0}};
        if (pin_active && state_q != ST_POWERUP) begin
            // pin reset: core and peripherals only, test port untouched
            state_q <= ST_POWERUP;
            sys_reset_q <= 1'b1;
            reset_cause_reg <= {{(`SRS_CAUSE_W-1){1'b0}}, 1'b1};
        end else begin
            case (state_q)
                ST_POWERUP: begin
                    sys_reset_q <= 1'b1;
                    cnt_q <= 32'h0;
                    if (!hold_inputs) begin
                        state_q <= ST_SETTLE;
                        por_seen_q <= 1'b1;
                        tap_reset_q <= 1'b0;
                        if (!por_seen_q)
                            reset_cause_reg[`SRS_CAUSE_POR] <= 1'b1;
                    end
                end
                ST_SETTLE: begin
                    // settling counter keeps internal reset held
                    if (cnt_q >= SETTLE_CYC - 1) begin
                        state_q <= ST_FETCH;
                        sys_reset_q <= 1'b0;
                        boot_phase_q <= `SRS_FETCH_SP;
                    end else
                        cnt_q <= cnt_q + 32'h1;
                end
                ST_PULSE: begin
                    if (cnt_q >= `SRS_PULSE_CYC - 1) begin
                        state_q <= ST_FETCH;
                        sys_reset_q <= 1'b0;
                        boot_phase_q <= `SRS_FETCH_SP;
                    end else
                        cnt_q <= cnt_q + 32'h1;
                end
                ST_FETCH: begin
                    // one cycle per fetch step, then run
                    case (boot_phase_q)
                        `SRS_FETCH_SP: boot_phase_q <= `SRS_FETCH_PC;
                        `SRS_FETCH_PC: boot_phase_q <= `SRS_FETCH_INSN;
                        `SRS_FETCH_INSN: begin
                            boot_phase_q <= `SRS_FETCH_RUN;
                            state_q <= ST_RUN;
                        end
                        // run phase never lingers in fetch
                        default: state_q <= ST_RUN;
                    endcase
                end
                ST_RUN: begin
                    // sources only act in run; a brown-out during a pulse just holds the flag
                    if (svc_reset) begin
                        state_q <= ST_PULSE;
                        sys_reset_q <= 1'b1;
                        cnt_q <= 32'h0;
                        if (bor_reset)
                            reset_cause_reg[`SRS_CAUSE_BOR] <= 1'b1;
                        if (wdt_second)
                            reset_cause_reg[`SRS_CAUSE_WDT] <= 1'b1;
                        if (sw_reset)
                            reset_cause_reg[`SRS_CAUSE_SW] <= 1'b1;
                        if (ldo_reset) begin
                            reset_cause_reg[`SRS_CAUSE_LDO] <= 1'b1;
                            regulator_reset_flag <= 1'b1;
                        end
                    end
                end
                default: state_q <= ST_POWERUP;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// brown-out: flag hold, resample, interrupt filter

always @(posedge sys_clk) begin
    if (!rst_b) begin
        brownout_flag_q <= 1'b0;
        bor_cnt_q <= 32'h0;
        bor_wait_q <= 1'b0;
        bor_res_q <= {DELAY_W{1'b0}};
        brownout_int_q <= 1'b0;
    end else if (clk_en) begin
        brownout_int_q <= 1'b0;
        if (brownout_flag_q) begin
            // flag held so software sees the original cause
            if (bor_cnt_q >= BOR_HOLD_CYC - 1) begin
                brownout_flag_q <= 1'b0;
                bor_cnt_q <= 32'h0;
            end else
                bor_cnt_q <= bor_cnt_q + 32'h1;
        end else if (bor_wait_q) begin
            if (bor_res_q == {DELAY_W{1'b0}}) begin
                bor_wait_q <= 1'b0;
                // absent at the recheck: nothing happens
                if (filt_ok) begin
                    brownout_int_q <= 1'b1;
                    brownout_flag_q <= 1'b1;
                end
            end else
                bor_res_q <= bor_res_q - {{(DELAY_W-1){1'b0}}, 1'b1};
        end else if (brownout_detect) begin
            if (bor_go_reset)
                brownout_flag_q <= 1'b1;
            else if (brownout_resample_en) begin
                bor_wait_q <= 1'b1;
                bor_res_q <= brownout_resample_delay;
            end else if (filt_ok) begin
                brownout_int_q <= 1'b1;
                brownout_flag_q <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// interrupt noise filter: last few comparator samples

always @(posedge sys_clk) begin
    if (!rst_b)
        filt_q <= {`SRS_FILT_LEN{1'b0}};
    else if (clk_en)
        filt_q <= {filt_q[`SRS_FILT_LEN-2:0], brownout_detect};
end

////////////////////////////////////////////////////////////////////////
// watchdog first time-out tracking

always @(posedge sys_clk) begin
    if (!rst_b)
        wdt_first_q <= 1'b0;
    else if (clk_en) begin
        // counter reloads itself; here only the stage is remembered
        if (!wdt_int_pending)
            wdt_first_q <= 1'b0;
        if (wdt_timeout)
            wdt_first_q <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// per-peripheral soft reset, bit order same as clock gating

wire [NUM_PERIPH*NUM_DOMAINS-1:0] periph_reset_d;

genvar gi;
generate
    for (gi = 0; gi < NUM_PERIPH; gi = gi + 1) begin : g_periph
        // held while bit set, released two cycles after clear; all domains together
        assign periph_reset_d[gi*NUM_DOMAINS +: NUM_DOMAINS] =
            {NUM_DOMAINS{periph_soft_reset_regs[gi] | soft_prev_q[gi] | sys_reset_q}};
    end
endgenerate

// one process owns both vectors, so every bit has a single driver
always @(posedge sys_clk) begin
    if (!rst_b) begin
        soft_prev_q <= {NUM_PERIPH{1'b0}};
        periph_reset_q <= {(NUM_PERIPH*NUM_DOMAINS){1'b1}};
    end else if (clk_en) begin
        soft_prev_q <= periph_soft_reset_regs;
        periph_reset_q <= periph_reset_d;
    end
end

endmodule // srs_reset_sequencer

// *** dv/srs_reset_sequencer_monitor.sv ***
`timescale 1ns/1ps
module srs_reset_sequencer_monitor #(
    parameter SETTLE_CYC = 20
) (
    input wire sys_clk,
    input wire rst_b,
    input wire ext_reset_pin_b,
    input wire brownout_reset_select,
    input wire core_system_reset_request,
    input wire regulator_reset_en,
    input wire regulator_unregulated,
    input wire sys_reset_q,
    input wire tap_reset_q,
    input wire [1:0] boot_phase_q,
    input wire brownout_int_q,
    input wire brownout_flag_q,
    input wire regulator_reset_flag,
    input wire [5:0] reset_cause_reg
);
    localparam int S = SETTLE_CYC;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_req_raises: assert property (core_system_reset_request && ext_reset_pin_b && boot_phase_q == 2'h3
        && !sys_reset_q |=> sys_reset_q && reset_cause_reg[4]) else $error("request ignored");
    a_pulse_holds: assert property ($rose(sys_reset_q) && ext_reset_pin_b |->
        sys_reset_q [*8] ##8 sys_reset_q ##1 !sys_reset_q) else $error("pulse width");
    a_boot_order: assert property ($fell(sys_reset_q) |-> boot_phase_q == 2'h0 ##1 boot_phase_q == 2'h1
        ##1 boot_phase_q == 2'h2 ##1 boot_phase_q == 2'h3) else $error("boot order");
    a_tap_low: assert property (!tap_reset_q |=> !tap_reset_q) else $error("tap reset again");
    a_pin_cause: assert property (!ext_reset_pin_b && !tap_reset_q |=>
        sys_reset_q && reset_cause_reg == 6'h01) else $error("pin cause");
    a_settle_time: assert property ($rose(ext_reset_pin_b) && !tap_reset_q |->
        ##S sys_reset_q ##[1:3] !sys_reset_q) else $error("settle time");
    a_int_only: assert property (brownout_int_q |-> !brownout_reset_select) else $error("int in reset mode");
    a_bor_hold: assert property ($rose(brownout_flag_q) |->
        brownout_flag_q [*8] ##[1:5] !brownout_flag_q) else $error("flag hold");
    a_reg_reset: assert property (regulator_unregulated && regulator_reset_en && ext_reset_pin_b
        && boot_phase_q == 2'h3 && !sys_reset_q |=> sys_reset_q && regulator_reset_flag) else $error("ldo");
endmodule // srs_reset_sequencer_monitor
bind srs_reset_sequencer srs_reset_sequencer_monitor #(.SETTLE_CYC(SETTLE_CYC)) mon_u (.*);

// *** dv/srs_core_model.sv ***
`timescale 1ns/1ps
module srs_core_model (
    input wire sys_clk,
    input wire sys_reset_q,
    input wire [1:0] boot_phase_q,
    input wire req_go,
    output logic core_system_reset_request = 1'b0,
    output logic order_bad = 1'b0
);
    logic [1:0] last_q = 2'h0;
    always @(posedge sys_clk) begin
        // held until reset is seen, so a slow answer is still caught
        if (req_go) core_system_reset_request <= 1'b1;
        else if (sys_reset_q) core_system_reset_request <= 1'b0;
        if (!sys_reset_q && boot_phase_q != last_q && boot_phase_q != last_q + 2'h1) order_bad <= 1'b1;
        last_q <= boot_phase_q;
    end
endmodule // srs_core_model

// *** dv/srs_reset_sequencer_tb.sv ***
`timescale 1ns/1ps
module srs_reset_sequencer_tb;
    localparam int SETTLE = 20;
    logic sys_clk = 0, rst_b = 0, ext_reset_pin_b = 0, por_detect = 1, brownout_detect = 0, req_go = 0;
    logic brownout_reset_ctrl_en = 0, brownout_reset_select = 0, wdt_timeout = 0, wdt_int_pending = 0;
    logic wdt_reset_en = 0, regulator_reset_en = 0, regulator_unregulated = 0, clk_en = 1;
    logic brownout_resample_en = 0, brownout_filter_en = 0, cause_clear = 0;
    logic [15:0] brownout_resample_delay = 16'h0000;
    logic [31:0] periph_soft_reset_regs = 32'h00000000;
    wire core_system_reset_request, sys_reset_q, tap_reset_q, brownout_int_q, brownout_flag_q;
    wire regulator_reset_flag, order_bad;
    wire [1:0] boot_phase_q;
    wire [5:0] reset_cause_reg;
    wire [63:0] periph_reset_q;
    int failures = 0, n_tests = 0, n;
    srs_reset_sequencer #(.SETTLE_CYC(SETTLE), .BOR_HOLD_CYC(10)) dut_u (.*);
    srs_core_model core_u (.*);
    initial forever #5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    // n = cycles the internal reset stays high
    task pulse_len;
        n = 0;
        while (sys_reset_q !== 1'b1 && n < 5) begin cyc(1); n++; end
        n = 0;
        while (sys_reset_q === 1'b1 && n < 100) begin cyc(1); n++; end
    endtask
    task run_wait;
        n = 0;
        while (!(boot_phase_q === 2'h3 && sys_reset_q === 1'b0) && n < 200) begin cyc(1); n++; end
        chk("running", 1, n < 200);
    endtask
    task complete_run;
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        failures++;
        complete_run;
    end
    initial begin
        cyc(2); rst_b = 1; cyc(2); por_detect = 0; cyc(3);
        ext_reset_pin_b = 1; pulse_len; chk("settle", SETTLE + 1, n);
        chk("tap", 0, tap_reset_q); run_wait; chk("por cause", 1, reset_cause_reg[1]);
        por_detect = 1; cyc(5); chk("por again", 0, sys_reset_q); por_detect = 0;
        req_go = 1; cyc(1); req_go = 0; pulse_len; chk("sw pulse", 16, n);
        chk("sw cause", 1, reset_cause_reg[4]); run_wait;
        ext_reset_pin_b = 0; cyc(3); ext_reset_pin_b = 1; pulse_len; chk("pin settle", SETTLE + 1, n);
        chk("pin cause", 6'h01, reset_cause_reg); chk("tap pin", 0, tap_reset_q); run_wait;
        brownout_detect = 1; n = 0;
        repeat (4) begin cyc(1); if (brownout_int_q === 1'b1) n++; end
        chk("bor int", 1, n); chk("bor off", 0, sys_reset_q); chk("bor flag", 1, brownout_flag_q);
        brownout_detect = 0; cyc(12);
        brownout_resample_en = 1; brownout_resample_delay = 16'h0004;
        brownout_detect = 1; cyc(1); brownout_detect = 0; cyc(8); chk("resample gone", 0, brownout_flag_q);
        brownout_detect = 1; n = 0;
        repeat (8) begin cyc(1); if (brownout_int_q === 1'b1) n++; end
        chk("resample int", 1, n); brownout_detect = 0; cyc(12); brownout_resample_en = 0;
        brownout_filter_en = 1; brownout_detect = 1; cyc(2); brownout_detect = 0; cyc(4);
        chk("filter short", 0, brownout_flag_q); brownout_detect = 1; n = 0;
        repeat (8) begin cyc(1); if (brownout_int_q === 1'b1) n++; end
        chk("filter int", 1, n); brownout_detect = 0; cyc(12); brownout_filter_en = 0;
        brownout_reset_ctrl_en = 1; brownout_reset_select = 1; cyc(2);
        brownout_detect = 1; cyc(1); brownout_detect = 0; pulse_len; chk("bor pulse", 16, n);
        chk("bor cause", 1, reset_cause_reg[2]); run_wait;
        brownout_reset_select = 0; brownout_reset_ctrl_en = 0; wdt_int_pending = 1; wdt_reset_en = 1;
        wdt_timeout = 1; cyc(1); wdt_timeout = 0; cyc(4); chk("wdt first", 0, sys_reset_q);
        wdt_timeout = 1; cyc(1); wdt_timeout = 0; pulse_len; chk("wdt pulse", 16, n);
        chk("wdt cause", 1, reset_cause_reg[3]); run_wait; wdt_int_pending = 0;
        regulator_reset_en = 1; regulator_unregulated = 1; cyc(1); regulator_unregulated = 0;
        pulse_len; chk("ldo pulse", 16, n); chk("ldo flag", 1, regulator_reset_flag);
        chk("ldo cause", 1, reset_cause_reg[5]); run_wait;
        clk_en = 0; periph_soft_reset_regs = 32'h00000020; cyc(2);
        chk("frozen", 0, periph_reset_q); clk_en = 1;
        periph_soft_reset_regs = 32'h00000020; cyc(2); chk("periph set", 64'h0000000000000C00, periph_reset_q);
        periph_soft_reset_regs = 32'h00000000; cyc(3); chk("periph clr", 0, periph_reset_q);
        chk("boot order", 0, order_bad);
        complete_run;
    end
endmodule // srs_reset_sequencer_tb
